// ===== aorfr_lane_rx.sv
// Serial lane receiver standing in for the host that collects results
module aorfr_lane_rx
	import aorfr_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        arm,
	input  wire logic [6:0]  nbits,
	input  wire logic        lane,
	output logic      [63:0] word,
	output logic             done
);
	logic       prev_r;
	logic       on_r;
	logic [1:0] ph_r;
	logic [6:0] cnt_r;

	// Frame opens on the first rising bit, so test data keep each MSB set;
	// sampling one cycle after the edge lands mid-bit for a 4-cycle bit
	always_ff @(posedge core_clk) begin
		prev_r <= lane;
		if (arm) begin
			on_r <= 1'b0;
			done <= 1'b0;
			cnt_r <= 7'h00;
			word <= 64'h0;
		end else if (!on_r && !done && lane && !prev_r) begin
			on_r <= 1'b1;
			ph_r <= 2'h0;
		end else if (on_r) begin
			ph_r <= ph_r + 2'h1;
			if (ph_r == 2'h0) begin
				word <= {word[62:0], lane};
				cnt_r <= cnt_r + 7'h01;
				if (cnt_r + 7'h01 == nbits) begin
					on_r <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// ===== aorfr_pkg.sv
// Shared constants, field layouts and carrier types of the lane/fault block
package aorfr_pkg;

	// Bus geometry: one register per aligned 32-bit word
	localparam int ADDR_BITS = 6;
	localparam int DATA_BITS = 32;
	localparam int WORD_BITS = 16;

	// Register indices; the byte address is four times the index
	localparam logic [3:0] IDX_ALERT_CTRL = 4'h1;
	localparam logic [3:0] IDX_LANE_CTRL  = 4'h2;
	localparam logic [3:0] IDX_FAULT      = 4'h3;
	localparam logic [3:0] IDX_LOW_THR    = 4'h4;
	localparam logic [3:0] IDX_HIGH_THR   = 4'h5;
	localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
	localparam logic [3:0] IDX_IRQ_MASK   = 4'h9;

	// Field positions inside a register word
	localparam int SEL_MSB      = 15;
	localparam int SEL_LSB      = 12;
	localparam int LANE_MSB     = 9;
	localparam int LANE_LSB     = 8;
	localparam int CODE_MSB     = 7;
	localparam int CODE_LSB     = 0;
	localparam int THR_MSB      = 11;
	localparam int ALERT_EN_BIT = 3;

	// Lane-select field encodings
	localparam logic [1:0] LANE_TWO   = 2'h0;
	localparam logic [1:0] LANE_ONE_A = 2'h1;
	localparam logic [1:0] LANE_FOUR  = 2'h2;
	localparam logic [1:0] LANE_ONE_B = 2'h3;

	// Reset field codes
	localparam logic [7:0] CODE_SOFT = 8'h3C;
	localparam logic [7:0] CODE_HARD = 8'hFF;

	// Values after reset
	localparam logic [1:0]  LANE_RST     = 2'h0;
	localparam logic        ALERT_EN_RST = 1'b0;
	localparam logic [11:0] LOW_THR_RST  = 12'h800;
	localparam logic [11:0] HIGH_THR_RST = 12'hFFF;
	localparam logic [3:0]  LOW_FILL     = 4'h0;
	localparam logic [3:0]  HIGH_FILL    = 4'hF;

	// Fault flag layout; channel n has low flag 2n and high flag 2n+1
	localparam int FAULT_BITS = 10;
	localparam int CRC_BIT    = 9;
	localparam int SETUP_BIT  = 8;
	localparam logic [9:0] FAULT_RST      = 10'h000;
	localparam logic [9:0] FAULT_COR_MASK = 10'h2FF;

	// Interrupt status layout
	localparam int IRQ_BITS  = 3;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_SOFT  = 1;
	localparam int IRQ_HARD  = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;

	// Serial output timing and lengths
	localparam int CHANNELS       = 4;
	localparam int SER_DIV_CYCLES = 4;
	localparam int DIV_W          = $clog2(SER_DIV_CYCLES);
	localparam logic [6:0] LEN_ONE  = 7'h40;
	localparam logic [6:0] LEN_TWO  = 7'h20;
	localparam logic [6:0] LEN_FOUR = 7'h10;

	// Four simultaneous results, channel A in the top bits
	typedef struct packed {
		logic [15:0] ch_a;
		logic [15:0] ch_b;
		logic [15:0] ch_c;
		logic [15:0] ch_d;
	} aorfr_results_t;

	// Serial output lanes
	typedef struct packed {
		logic a;
		logic b;
		logic c;
		logic d;
	} aorfr_lanes_t;

	typedef enum logic {SER_IDLE, SER_SHIFT} aorfr_ser_state_t;

endpackage

// ===== aorfr_regs.sv
// Lane control, reset codes and sticky fault flags behind an Avalon slave
//
// Implementation choice: register access over Avalon-MM.
module aorfr_regs
	import aorfr_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic [ADDR_BITS-1:0] avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [DATA_BITS-1:0] avs_writedata,
	output logic      [DATA_BITS-1:0] avs_readdata,
	output logic                      avs_waitrequest,
	input  wire logic                 result_valid,
	input  wire aorfr_results_t       results,
	input  wire logic                 crc_write_error,
	input  wire logic                 setup_load_error,
	output logic                      result_lane_a,
	output logic                      result_lane_b,
	output logic                      result_lane_c,
	output logic                      result_lane_d_shared_pin,
	output logic                      setup_restart,
	output logic                      irq
);

	logic [1:0]            lane_ctrl_r;
	logic                  alert_en_r;
	logic [11:0]           low_thr_r;
	logic [11:0]           high_thr_r;
	logic [FAULT_BITS-1:0] fault_r;
	logic [FAULT_BITS-1:0] fault_set;
	logic [FAULT_BITS-1:0] fault_clr;
	logic [IRQ_BITS-1:0]   irq_status_r;
	logic [IRQ_BITS-1:0]   irq_status_nxt;
	logic [IRQ_BITS-1:0]   irq_mask_r;
	logic [IRQ_BITS-1:0]   irq_mask_nxt;
	logic [IRQ_BITS-1:0]   irq_event;
	logic [3:0]            idx;
	logic                  sel_ok;
	logic                  wr_acc;
	logic                  rd_acc;
	logic                  lane_wr;
	logic                  soft_pulse;
	logic                  hard_pulse;
	logic                  fault_rd;
	logic                  alert_level;
	logic [WORD_BITS-1:0]  rd_word;
	logic [15:0]           chan [CHANNELS];
	aorfr_lanes_t          ser_lanes;
	logic                  ser_busy;

	// Result strictly above the high limit, low nibble filled with ones
	function automatic logic over_high(input logic [15:0] res,
		input logic [11:0] thr);
		over_high = (res > {thr, HIGH_FILL});
	endfunction

	// Result strictly below the low limit, low nibble filled with zeros
	function automatic logic under_low(input logic [15:0] res,
		input logic [11:0] thr);
		under_low = (res < {thr, LOW_FILL});
	endfunction

	// Access decode; the word's own select field must name the register
	assign idx        = avs_address[5:2];
	assign sel_ok     = (avs_writedata[SEL_MSB:SEL_LSB] == idx);
	assign wr_acc     = avs_write && !avs_waitrequest;
	assign rd_acc     = avs_read && !avs_waitrequest;
	assign lane_wr    = wr_acc && (idx == IDX_LANE_CTRL) && sel_ok;
	assign soft_pulse = lane_wr &&
		(avs_writedata[CODE_MSB:CODE_LSB] == CODE_SOFT);
	assign hard_pulse = lane_wr &&
		(avs_writedata[CODE_MSB:CODE_LSB] == CODE_HARD);
	assign fault_rd   = rd_acc && (idx == IDX_FAULT);

	// One wait state per access: answer on the second cycle of a request
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			avs_waitrequest <= 1'b1;
		else if ((avs_read || avs_write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	// Read word; every mapped register echoes its index in the top bits
	always_comb begin
		rd_word = '0;
		if (idx == IDX_ALERT_CTRL) begin
			rd_word[ALERT_EN_BIT] = alert_en_r;
		end else if (idx == IDX_LANE_CTRL) begin
			rd_word[LANE_MSB:LANE_LSB] = lane_ctrl_r;
		end else if (idx == IDX_FAULT) begin
			rd_word[FAULT_BITS-1:0] = fault_r;
		end else if (idx == IDX_LOW_THR) begin
			rd_word[THR_MSB:0] = low_thr_r;
		end else if (idx == IDX_HIGH_THR) begin
			rd_word[THR_MSB:0] = high_thr_r;
		end else if (idx == IDX_IRQ_STATUS) begin
			rd_word[IRQ_BITS-1:0] = irq_status_r;
		end else if (idx == IDX_IRQ_MASK) begin
			rd_word[IRQ_BITS-1:0] = irq_mask_r;
		end
		if (idx == IDX_ALERT_CTRL || idx == IDX_LANE_CTRL ||
			idx == IDX_FAULT || idx == IDX_LOW_THR ||
			idx == IDX_HIGH_THR || idx == IDX_IRQ_STATUS ||
			idx == IDX_IRQ_MASK)
			rd_word[SEL_MSB:SEL_LSB] = idx;
	end

	// Read data is caught in the wait cycle and stands until the next read
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			avs_readdata <= '0;
		else if (avs_read && avs_waitrequest)
			avs_readdata <= {16'h0000, rd_word};
	end

	// Lane mode; a hard reset wins over the lane field in the same word
	always_ff @(posedge core_clk) begin
		if (!rst_n || hard_pulse)
			lane_ctrl_r <= LANE_RST;
		else if (lane_wr)
			lane_ctrl_r <= avs_writedata[LANE_MSB:LANE_LSB];
	end

	// Alert enable and both thresholds return to defaults on hard reset
	always_ff @(posedge core_clk) begin
		if (!rst_n || hard_pulse) begin
			alert_en_r <= ALERT_EN_RST;
			low_thr_r  <= LOW_THR_RST;
			high_thr_r <= HIGH_THR_RST;
		end else if (wr_acc && sel_ok) begin
			if (idx == IDX_ALERT_CTRL)
				alert_en_r <= avs_writedata[ALERT_EN_BIT];
			else if (idx == IDX_LOW_THR)
				low_thr_r <= avs_writedata[THR_MSB:0];
			else if (idx == IDX_HIGH_THR)
				high_thr_r <= avs_writedata[THR_MSB:0];
		end
	end

	// Channel results in index order for the comparator loop
	assign chan[0] = results.ch_a;
	assign chan[1] = results.ch_b;
	assign chan[2] = results.ch_c;
	assign chan[3] = results.ch_d;

	// Events raised this cycle; all sources share core_clk
	always_comb begin
		fault_set = '0;
		fault_set[CRC_BIT]   = crc_write_error;
		fault_set[SETUP_BIT] = setup_load_error;
		if (result_valid) begin
			for (int n = 0; n < CHANNELS; n++) begin
				fault_set[2*n+1] = over_high(chan[n], high_thr_r);
				fault_set[2*n]   = under_low(chan[n], low_thr_r);
			end
		end
	end

	// Only bits that went out in the read word are cleared, so an event
	// that lands between capture and accept survives to the next read
	assign fault_clr = fault_rd ?
		(avs_readdata[FAULT_BITS-1:0] & FAULT_COR_MASK) : '0;

	// Sticky fault flags; a set in the clearing cycle wins
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			fault_r <= FAULT_RST;
		else if (hard_pulse)
			fault_r <= fault_set;
		else if (soft_pulse)
			fault_r <= (fault_r & ~FAULT_COR_MASK) | fault_set;
		else
			fault_r <= (fault_r & ~fault_clr) | fault_set;
	end

	// Interrupt status, write one to clear, event wins over the clear
	assign irq_event[IRQ_FAULT] = |(fault_set & ~fault_r);
	assign irq_event[IRQ_SOFT]  = soft_pulse;
	assign irq_event[IRQ_HARD]  = hard_pulse;
	always_comb begin
		irq_status_nxt = irq_status_r | irq_event;
		irq_mask_nxt   = irq_mask_r;
		if (wr_acc && sel_ok && idx == IDX_IRQ_STATUS)
			irq_status_nxt = (irq_status_r &
				~avs_writedata[IRQ_BITS-1:0]) | irq_event;
		if (wr_acc && sel_ok && idx == IDX_IRQ_MASK)
			irq_mask_nxt = avs_writedata[IRQ_BITS-1:0];
	end

	// Interrupt registers are bus-side and survive the hard reset code
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_status_r <= IRQ_RST;
			irq_mask_r   <= IRQ_RST;
			irq          <= 1'b0;
		end else begin
			irq_status_r <= irq_status_nxt;
			irq_mask_r   <= irq_mask_nxt;
			irq          <= |(irq_status_nxt & irq_mask_nxt);
		end
	end

	// Serialiser starts on a fresh result only when idle
	aorfr_serializer u_ser (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.flush     (soft_pulse || hard_pulse),
		.start     (result_valid && !ser_busy),
		.results   (results),
		.lane_mode (lane_ctrl_r),
		.lanes     (ser_lanes),
		.busy      (ser_busy)
	);

	assign alert_level = |fault_r[7:0];

	// Pin stage; the shared pin shows the alert only in lane code 01
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			result_lane_a            <= 1'b0;
			result_lane_b            <= 1'b0;
			result_lane_c            <= 1'b0;
			result_lane_d_shared_pin <= 1'b0;
		end else begin
			result_lane_a <= ser_lanes.a;
			result_lane_b <= ser_lanes.b;
			result_lane_c <= ser_lanes.c;
			if (lane_ctrl_r == LANE_FOUR)
				result_lane_d_shared_pin <= ser_lanes.d;
			else if (lane_ctrl_r == LANE_ONE_A && alert_en_r)
				result_lane_d_shared_pin <= alert_level;
			else
				result_lane_d_shared_pin <= 1'b0;
		end
	end

	// Restart pulse for the setup loader after a hard reset
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			setup_restart <= 1'b0;
		else
			setup_restart <= hard_pulse;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sel_echo_a: assert property (
		avs_read && avs_waitrequest && idx == IDX_FAULT
		|=> avs_readdata[SEL_MSB:SEL_LSB] == IDX_FAULT)
		else $error("read word lacks register select");

	two_lane_a: assert property (
		(lane_ctrl_r == LANE_TWO)[*3] |-> !result_lane_c)
		else $error("lane C active in two-lane mode");

	one_lane_a: assert property (
		(lane_ctrl_r == LANE_ONE_B)[*3] |-> !result_lane_b &&
		!result_lane_c && !result_lane_d_shared_pin)
		else $error("extra lane active in one-lane mode");

	four_lane_a: assert property (
		lane_ctrl_r == LANE_FOUR |=>
		result_lane_d_shared_pin == $past(ser_lanes.d))
		else $error("shared pin not carrying lane D");

	soft_reset_a: assert property (
		soft_pulse |=> $stable(low_thr_r) && $stable(high_thr_r) &&
		((fault_r & FAULT_COR_MASK) ==
		($past(fault_set) & FAULT_COR_MASK)) && !ser_busy)
		else $error("soft reset effect wrong");

	hard_reset_a: assert property (
		hard_pulse |=> lane_ctrl_r == LANE_RST &&
		low_thr_r == LOW_THR_RST && high_thr_r == HIGH_THR_RST &&
		alert_en_r == ALERT_EN_RST && setup_restart)
		else $error("hard reset did not restore defaults");

	ignore_code_a: assert property (
		lane_wr && avs_writedata[CODE_MSB:CODE_LSB] != CODE_SOFT &&
		avs_writedata[CODE_MSB:CODE_LSB] != CODE_HARD
		|=> !setup_restart && $stable(low_thr_r) &&
		!$rose(irq_status_r[IRQ_SOFT]))
		else $error("unknown reset code took effect");

	crc_flag_a: assert property (
		crc_write_error |=> fault_r[CRC_BIT] ##1
		(fault_r[CRC_BIT] || $past(fault_rd) || $past(soft_pulse) ||
		$past(hard_pulse)))
		else $error("CRC flag lost");

	setup_hold_a: assert property (
		fault_r[SETUP_BIT] && !hard_pulse |=> fault_r[SETUP_BIT])
		else $error("setup flag cleared without hard reset");

	high_alert_a: assert property (
		result_valid && results.ch_a > {high_thr_r, HIGH_FILL}
		|=> fault_r[1])
		else $error("high alert on channel A missed");

	low_alert_a: assert property (
		result_valid && results.ch_b < {low_thr_r, LOW_FILL}
		|=> fault_r[2])
		else $error("low alert on channel B missed");

	alert_pin_a: assert property (
		lane_ctrl_r == LANE_ONE_A && alert_en_r
		|=> result_lane_d_shared_pin == $past(alert_level))
		else $error("alert pin does not follow flags");

	read_clear_a: assert property (
		fault_rd && !soft_pulse && !hard_pulse
		|=> ((fault_r & ~$past(fault_set)) &
		$past(avs_readdata[FAULT_BITS-1:0]) & FAULT_COR_MASK) == '0)
		else $error("read did not clear captured flags");

	read_keep_a: assert property (
		fault_rd |=> (fault_r & $past(fault_set)) == $past(fault_set))
		else $error("event during read was lost");

	soft_seen_c: cover property (soft_pulse ##1 !ser_busy);
	hard_seen_c: cover property (hard_pulse ##1 setup_restart);
	read_race_c: cover property (fault_rd && |fault_set);
	four_lane_c: cover property (lane_ctrl_r == LANE_FOUR && ser_busy);
	alert_pin_c: cover property (lane_ctrl_r == LANE_ONE_A && alert_en_r &&
		alert_level);

endmodule

// ===== aorfr_serializer.sv
// Shifts one frame of four results out over one, two or four lanes
module aorfr_serializer
	import aorfr_pkg::*;
(
	input  wire logic           core_clk,
	input  wire logic           rst_n,
	input  wire logic           flush,
	input  wire logic           start,
	input  wire aorfr_results_t results,
	input  wire logic [1:0]     lane_mode,
	output aorfr_lanes_t        lanes,
	output logic                busy
);

	aorfr_ser_state_t state_r;
	logic [63:0]      shift_r;
	logic [6:0]       count_r;
	logic [DIV_W-1:0] div_r;
	logic             bit_en;

	// Bits each lane carries for one frame
	function automatic logic [6:0] lane_len(input logic [1:0] mode);
		case (mode)
			LANE_TWO:  lane_len = LEN_TWO;
			LANE_FOUR: lane_len = LEN_FOUR;
			default:   lane_len = LEN_ONE;
		endcase
	endfunction

	// Free-running divider gives the bit-rate enable
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end
	assign bit_en = (div_r == DIV_W'(SER_DIV_CYCLES - 1));

	// Frame sequencer; a flush abandons the frame at once
	always_ff @(posedge core_clk) begin
		if (!rst_n || flush) begin
			state_r <= SER_IDLE;
			shift_r <= '0;
			count_r <= '0;
			lanes   <= '0;
		end else begin
			case (state_r)
				SER_IDLE: begin
					if (start) begin
						shift_r <= results;
						count_r <= lane_len(lane_mode);
						state_r <= SER_SHIFT;
					end
				end
				SER_SHIFT: begin
					if (bit_en) begin
						if (count_r == 7'h00) begin
							lanes   <= '0;
							state_r <= SER_IDLE;
						end else begin
							// Quarter taps follow the frame as it shifts
							lanes.a <= shift_r[63];
							lanes.b <= (lane_mode == LANE_TWO) ? shift_r[31] :
								(lane_mode == LANE_FOUR) ? shift_r[47] : 1'b0;
							lanes.c <= (lane_mode == LANE_FOUR) && shift_r[31];
							lanes.d <= (lane_mode == LANE_FOUR) && shift_r[15];
							shift_r <= {shift_r[62:0], 1'b0};
							count_r <= count_r - 7'h01;
						end
					end
				end
				default: state_r <= SER_IDLE;
			endcase
		end
	end

	assign busy = (state_r == SER_SHIFT);

endmodule

// ===== aorfr_wait_note.sv
// Bus timing: every register access is answered after one wait state

// ===== tb_adc_output_reset_fault_regs.sv
// Register, fault flag and lane tests of the lane/fault block
module tb_adc_output_reset_fault_regs
	import aorfr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam aorfr_results_t FR = 64'hA5C3_96E1_C33C_F00F;
	logic                 core_clk;
	logic                 rst_n;
	logic [ADDR_BITS-1:0] avs_address;
	logic                 avs_read;
	logic                 avs_write;
	logic [DATA_BITS-1:0] avs_writedata;
	logic [DATA_BITS-1:0] avs_readdata;
	logic                 avs_waitrequest;
	logic                 result_valid;
	aorfr_results_t       results;
	logic                 crc_write_error;
	logic                 setup_load_error;
	logic [3:0]           ln;
	logic                 setup_restart;
	logic                 irq;
	logic                 arm;
	logic [6:0]           nb;
	logic [63:0]          wd [4];
	logic [3:0]           dn;
	int                   n_mismatch;
	int                   samples_checked;
	int                   n_rst;
	logic [15:0]          rv [10] = '{16'h0000, 16'h1000, 16'h2000,
		16'h3000, 16'h4800, 16'h5FFF, 16'h0000, 16'h0000, 16'h8000,
		16'h9000};

	aorfr_regs DUT (
		.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .result_valid(result_valid),
		.results(results), .crc_write_error(crc_write_error),
		.setup_load_error(setup_load_error), .result_lane_a(ln[3]),
		.result_lane_b(ln[2]), .result_lane_c(ln[1]),
		.result_lane_d_shared_pin(ln[0]), .setup_restart(setup_restart),
		.irq(irq));

	// One receiver per lane, index 3 is lane A
	for (genvar g = 0; g < 4; g++) begin : rx
		aorfr_lane_rx u (.core_clk(core_clk), .arm(arm), .nbits(nb),
			.lane(ln[g]), .word(wd[g]), .done(dn[g]));
	end

	always #5 core_clk = ~core_clk;

	// Restart pulses are counted so a missing or doubled one shows up
	always @(posedge core_clk) begin
		if (setup_restart === 1'b1)
			n_rst++;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Holds the request until waitrequest is sampled low; one idle edge
	// follows so the next call never reassigns in the same time step;
	// a slave that never answers is left to the watchdog
	task automatic bus(input logic w, input logic [3:0] idx,
		input logic [15:0] d, output logic [31:0] q);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {16'h0000, d};
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [3:0] idx, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task automatic rd(input logic [3:0] idx, input logic [15:0] e);
		logic [31:0] q;
		bus(1'b0, idx, 16'h0000, q);
		chk({32'h0, q}, {48'h0, e});
	endtask

	// Level outputs lag their cause, so two edges pass before a look;
	// the level is read after the wait, not copied in at the call
	task automatic chk_bit(input logic on_pin, input logic e);
		repeat (2) @(posedge core_clk);
		chk({63'h0, on_pin ? ln[0] : irq}, {63'h0, e});
	endtask

	task automatic pulse_res(input aorfr_results_t r);
		results <= r;
		result_valid <= 1'b1;
		@(posedge core_clk);
		result_valid <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic ev(input logic crc, input logic setup);
		crc_write_error <= crc;
		setup_load_error <= setup;
		@(posedge core_clk);
		crc_write_error <= 1'b0;
		setup_load_error <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic frame(input logic [1:0] m);
		int n;
		logic [3:0] em;
		logic [63:0] ex [4];
		n = 0;
		ex = '{default: 64'h0};
		case (m)
			LANE_TWO: begin
				nb <= LEN_TWO;
				em = 4'b1100;
				ex[3] = {32'h0, FR[63:32]};
				ex[2] = {32'h0, FR[31:0]};
			end
			LANE_FOUR: begin
				nb <= LEN_FOUR;
				em = 4'b1111;
				for (int i = 0; i < 4; i++)
					ex[i] = {48'h0, FR[16*i +: 16]};
			end
			default: begin
				nb <= LEN_ONE;
				em = 4'b1000;
				ex[3] = FR;
			end
		endcase
		arm <= 1'b1;
		@(posedge core_clk);
		arm <= 1'b0;
		pulse_res(FR);
		while (dn[3] !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		repeat (8) @(posedge core_clk);
		chk({60'h0, dn}, {60'h0, em});
		for (int i = 0; i < 4; i++)
			if (em[i])
				chk(wd[i], ex[i]);
	endtask

	// Watchdog sized well above the thousand or so cycles the tests need
	initial begin
		#200000;
		n_mismatch++;
		print_verdict;
	end

	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		result_valid = 1'b0;
		results = '0;
		crc_write_error = 1'b0;
		setup_load_error = 1'b0;
		arm = 1'b1;
		nb = LEN_ONE;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		arm <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 10; i++)
			rd(4'(i), rv[i]);
		wr(IDX_LANE_CTRL, 16'h5200);
		rd(IDX_LANE_CTRL, 16'h2000);
		wr(IDX_FAULT, 16'h33FF);
		rd(IDX_FAULT, 16'h3000);
		$display("test reset and select done");
		wr(IDX_LOW_THR, 16'h4100);
		wr(IDX_HIGH_THR, 16'h5EFF);
		pulse_res({16'h0FFF, 16'h1000, 16'hEFFF, 16'hF000});
		rd(IDX_FAULT, 16'h3081);
		rd(IDX_FAULT, 16'h3000);
		pulse_res({16'hF000, 16'h0000, 16'h0FFF, 16'h0000});
		rd(IDX_FAULT, 16'h3056);
		pulse_res({16'h8000, 16'hF000, 16'hF000, 16'h8000});
		rd(IDX_FAULT, 16'h3028);
		$display("test alert flags done");
		rd(IDX_IRQ_STATUS, 16'h8001);
		chk_bit(1'b0, 1'b0);
		wr(IDX_IRQ_MASK, 16'h9001);
		chk_bit(1'b0, 1'b1);
		wr(IDX_IRQ_STATUS, 16'h8001);
		chk_bit(1'b0, 1'b0);
		rd(IDX_IRQ_STATUS, 16'h8000);
		$display("test interrupt done");
		ev(1'b1, 1'b1);
		rd(IDX_FAULT, 16'h3300);
		rd(IDX_FAULT, 16'h3100);
		foreach (rv[i]) begin
			ev(1'b1, 1'b0);
			wr(IDX_LANE_CTRL, {8'h22, 8'h11 * 8'(i) + 8'h01});
			rd(IDX_FAULT, 16'h3300);
		end
		chk(64'(n_rst), 64'h0);
		wr(IDX_LANE_CTRL, 16'h213C);
		rd(IDX_FAULT, 16'h3100);
		rd(IDX_LANE_CTRL, 16'h2100);
		rd(IDX_LOW_THR, 16'h4100);
		rd(IDX_IRQ_STATUS, 16'h8003);
		wr(IDX_LANE_CTRL, 16'h22FF);
		rd(IDX_FAULT, 16'h3000);
		rd(IDX_LANE_CTRL, 16'h2000);
		rd(IDX_LOW_THR, 16'h4800);
		rd(IDX_HIGH_THR, 16'h5FFF);
		rd(IDX_IRQ_MASK, 16'h9001);
		rd(IDX_IRQ_STATUS, 16'h8007);
		chk(64'(n_rst), 64'h1);
		// An event landing in the read's wait cycle must survive it
		fork
			rd(IDX_FAULT, 16'h3000);
			ev(1'b1, 1'b0);
		join
		rd(IDX_FAULT, 16'h3200);
		$display("test reset codes done");
		for (int m = 0; m < 4; m++) begin
			wr(IDX_LANE_CTRL, {IDX_LANE_CTRL, 2'b00, 2'(m), 8'h00});
			frame(2'(m));
		end
		$display("test lanes done");
		wr(IDX_LANE_CTRL, 16'h2100);
		wr(IDX_ALERT_CTRL, 16'h1008);
		wr(IDX_LOW_THR, 16'h4FFF);
		pulse_res(FR);
		chk_bit(1'b1, 1'b1);
		wr(IDX_LANE_CTRL, 16'h2300);
		chk_bit(1'b1, 1'b0);
		wr(IDX_LANE_CTRL, 16'h2100);
		chk_bit(1'b1, 1'b1);
		wr(IDX_ALERT_CTRL, 16'h1000);
		chk_bit(1'b1, 1'b0);
		$display("test shared pin done");
		print_verdict;
	end
endmodule
